// [design/interrupt_enable_bank.sv]
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "irq_enable_defines.svh"

module interrupt_enable_bank (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire irq_enable_pkg::apb_req_type     apb_req,
    output irq_enable_pkg::apb_rsp_type          apb_rsp,
    input  wire irq_enable_pkg::bank_type        src_event,
    input  wire irq_enable_pkg::level_table_type src_level,
    output irq_enable_pkg::bank_type             src_req,
    output logic                                 irq
);
    import irq_enable_pkg::*;

    // ****************************************************
    // Bank constants
    // ****************************************************
    localparam bank_type IMPL = {`MASK_BANK4, `MASK_BANK3,
                                 `MASK_BANK2, `MASK_BANK1};

    // ****************************************************
    // Declarations
    // ****************************************************
    phase_type    phase_q;
    phase_type    phase_d;
    logic [31:0]  rdata_q;
    logic [31:0]  rdata_d;
    logic         err_q;
    logic         err_d;

    bank_type     en_q;
    bank_type     en_d;
    bank_type     flag_q;
    bank_type     flag_d;
    bank_type     req_w;
    bank_type     req_prev_q;
    bank_type     req_prev_d;

    irq_bits_type status_q;
    irq_bits_type status_d;
    irq_bits_type mask_q;
    irq_bits_type mask_d;
    logic         irq_q;
    logic         irq_d;

    logic         setup;
    logic         access;
    logic         wr_fire;
    logic [3:0]   hit_en;
    logic [3:0]   hit_flag;
    logic         hit_status;
    logic         hit_mask;
    logic         hit_any;
    irq_bits_type bank_rise;

    // ****************************************************
    // Address decode
    // ****************************************************
    assign setup   = apb_req.psel & ~apb_req.penable;
    assign access  = apb_req.psel & apb_req.penable
                     & (phase_q == PH_ACCESS);
    assign wr_fire = access & apb_req.pwrite;

    always_comb begin
        hit_en[0]   = (apb_req.paddr == `OFS_EN1);
        hit_en[1]   = (apb_req.paddr == `OFS_EN2);
        hit_en[2]   = (apb_req.paddr == `OFS_EN3);
        hit_en[3]   = (apb_req.paddr == `OFS_EN4);
        hit_flag[0] = (apb_req.paddr == `OFS_FLAG1);
        hit_flag[1] = (apb_req.paddr == `OFS_FLAG2);
        hit_flag[2] = (apb_req.paddr == `OFS_FLAG3);
        hit_flag[3] = (apb_req.paddr == `OFS_FLAG4);
        hit_status  = (apb_req.paddr == `OFS_IRQ_STATUS);
        hit_mask    = (apb_req.paddr == `OFS_IRQ_MASK);
        hit_any     = (|hit_en) | (|hit_flag) | hit_status | hit_mask;
    end

    // ****************************************************
    // Bus phase tracking
    // ****************************************************
    // One wait-free access phase; read data is latched in setup so
    // that prdata comes from a flop without adding a wait state.
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE: begin
                if (setup) begin
                    phase_d = PH_ACCESS;
                end
            end
            PH_ACCESS: begin
                if (access) begin
                    phase_d = PH_IDLE;
                end else if (!apb_req.psel) begin
                    phase_d = PH_IDLE;
                end
            end
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PH_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ****************************************************
    // Read data and error capture
    // ****************************************************
    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup && (phase_q == PH_IDLE)) begin
            rdata_d = `READ_ZERO;
            err_d   = ~hit_any;
            // Writes leave the data register at zero, so a stale
            // word never shows during a write access
            if (!apb_req.pwrite) begin
                case (apb_req.paddr)
                    `OFS_EN1: begin
                        // Unimplemented positions never hold a one
                        rdata_d = {`HI_ZERO, en_q[0]};
                    end
                    `OFS_EN2: begin
                        rdata_d = {`HI_ZERO, en_q[1]};
                    end
                    `OFS_EN3: begin
                        rdata_d = {`HI_ZERO, en_q[2]};
                    end
                    `OFS_EN4: begin
                        rdata_d = {`HI_ZERO, en_q[3]};
                    end
                    `OFS_FLAG1: begin
                        rdata_d = {`HI_ZERO, flag_q[0]};
                    end
                    `OFS_FLAG2: begin
                        rdata_d = {`HI_ZERO, flag_q[1]};
                    end
                    `OFS_FLAG3: begin
                        rdata_d = {`HI_ZERO, flag_q[2]};
                    end
                    `OFS_FLAG4: begin
                        rdata_d = {`HI_ZERO, flag_q[3]};
                    end
                    `OFS_IRQ_STATUS: begin
                        rdata_d = {`HI_ZERO_IRQ, status_q};
                    end
                    `OFS_IRQ_MASK: begin
                        rdata_d = {`HI_ZERO_IRQ, mask_q};
                    end
                    default: begin
                        // Holes read zero; the error flag marks them
                        rdata_d = `READ_ZERO;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= `READ_ZERO;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // ****************************************************
    // Bus response
    // ****************************************************
    // Ready is combinational to keep the access phase wait-free
    assign apb_rsp.prdata  = rdata_q;
    assign apb_rsp.pready  = access;
    assign apb_rsp.pslverr = access & err_q;

    // ****************************************************
    // Enable registers
    // ****************************************************
    // External pin enables take effect here regardless of pin routing;
    // without a routed remappable pin the pin event never arrives.
    always_comb begin
        en_d = en_q;
        for (int b = 0; b < 4; b++) begin
            if (wr_fire && hit_en[b]) begin
                en_d[b] = apb_req.pwdata[15:0] & IMPL[b];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= {4{`RST_WORD}};
        end else begin
            en_q <= en_d;
        end
    end

    // ****************************************************
    // Source flag registers
    // ****************************************************
    // A source event in the same cycle as a software write wins.
    always_comb begin
        flag_d = flag_q;
        for (int b = 0; b < 4; b++) begin
            if (wr_fire && hit_flag[b]) begin
                flag_d[b] = apb_req.pwdata[15:0];
            end
            flag_d[b] = (flag_d[b] | src_event[b]) & IMPL[b];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= {4{`RST_WORD}};
        end else begin
            flag_q <= flag_d;
        end
    end

    // ****************************************************
    // Gated request banks
    // ****************************************************
    for (genvar g = 0; g < 4; g++) begin : gen_bank
        irq_gate_bank #(
            .IMPL_MASK (IMPL[g])
        ) u_gate (
            .pclk      (pclk),
            .presetn   (presetn),
            .flag      (flag_q[g]),
            .enable    (en_q[g]),
            .level     (src_level[g]),
            .req_q     (req_w[g])
        );
    end

    assign src_req = req_w;

    // ****************************************************
    // Summary interrupt: status, mask, output
    // ****************************************************
    // A bank event is any request that newly rises in that bank.
    always_comb begin
        req_prev_d = req_w;
        for (int b = 0; b < 4; b++) begin
            bank_rise[b] = |(req_w[b] & ~req_prev_q[b]);
        end
    end

    always_comb begin
        status_d = status_q;
        mask_d   = mask_q;
        if (wr_fire && hit_status) begin
            status_d = status_q & ~apb_req.pwdata[3:0];
        end
        if (wr_fire && hit_mask) begin
            mask_d = apb_req.pwdata[3:0];
        end
        // Set after clear so a same-cycle event is never lost
        status_d = status_d | bank_rise;
        irq_d    = |(status_d & mask_d);
    end

    // Cleared on reset so no false rise is seen after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prev_q <= {4{`RST_WORD}};
        end else begin
            req_prev_q <= req_prev_d;
        end
    end

    // ****************************************************
    // Summary registers
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q   <= `RST_IRQ;
            mask_q     <= `RST_IRQ;
            irq_q      <= 1'b0;
        end else begin
            status_q   <= status_d;
            mask_q     <= mask_d;
            irq_q      <= irq_d;
        end
    end

    assign irq = irq_q;

endmodule

// [design/irq_enable_defines.svh]
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define OFS_EN1         8'h00
`define OFS_EN2         8'h04
`define OFS_EN3         8'h08
`define OFS_EN4         8'h0c
`define OFS_FLAG1       8'h10
`define OFS_FLAG2       8'h14
`define OFS_FLAG3       8'h18
`define OFS_FLAG4       8'h1c
`define OFS_IRQ_STATUS  8'h20
`define OFS_IRQ_MASK    8'h24

// ****************************************************
// Implemented bit masks per bank
// ****************************************************
// Bank 1: 15 tx2 14 rx2 13 pin2 12 t5 11 t4 10 oc4 9 oc3
//         7 ic8 6 ic7 4 pin1 3 change 2 comparator 1 i2c1m 0 i2c1s
`define MASK_BANK1      16'hfedf
// Bank 2: 13 parallel 12-9 oc8-oc5 8-5 ic6-ic3 1 spi2 0 spi2 fault
`define MASK_BANK2      16'h3fe3
// Bank 3: 14 calendar 6 pin4 5 pin3 2 i2c2m 1 i2c2s
`define MASK_BANK3      16'h4066
// Bank 4: 13 charge time 8 low voltage 3 crc 2 serial2 err 1 serial1 err
`define MASK_BANK4      16'h210e

// ****************************************************
// Reset values and constants
// ****************************************************
`define RST_WORD        16'h0000
`define RST_IRQ         4'h0
`define LEVEL_OFF       3'h0
`define READ_ZERO       32'h0000_0000
`define HI_ZERO         16'h0000
`define HI_ZERO_IRQ     28'h000_0000

`endif

// [design/irq_enable_pkg.sv]
package irq_enable_pkg;

    typedef logic [15:0]             word_type;
    typedef word_type [3:0]          bank_type;
    typedef logic [2:0]              level_type;
    typedef level_type [15:0]        level_row_type;
    typedef level_row_type [3:0]     level_table_type;
    typedef logic [3:0]              irq_bits_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b01,
        PH_ACCESS = 2'b10
    } phase_type;

endpackage

// [design/irq_gate_bank.sv]
`timescale 1ns/1ps
`include "irq_enable_defines.svh"

module irq_gate_bank #(
    parameter logic [15:0] IMPL_MASK = 16'hffff
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire irq_enable_pkg::word_type      flag,
    input  wire irq_enable_pkg::word_type      enable,
    input  wire irq_enable_pkg::level_row_type level,
    output irq_enable_pkg::word_type           req_q
);
    import irq_enable_pkg::*;

    word_type req_d;

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            req_d[i] = flag[i] & enable[i] & IMPL_MASK[i]
                       & (level[i] != `LEVEL_OFF);
        end
    end

    // Registered so requests rise one edge after flag and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= `RST_WORD;
        end else begin
            req_q <= req_d;
        end
    end

endmodule

// [tb/irq_enable_assertions.sv]
`timescale 1ns/1ps
module irq_enable_assertions (
    input wire logic                            pclk,
    input wire logic                            presetn,
    input wire irq_enable_pkg::apb_req_type     apb_req,
    input wire irq_enable_pkg::apb_rsp_type     apb_rsp,
    input wire irq_enable_pkg::bank_type        src_event,
    input wire irq_enable_pkg::level_table_type src_level,
    input wire irq_enable_pkg::bank_type        src_req,
    input wire logic                            irq
);
    import irq_enable_pkg::*;
    localparam bank_type IMPL = {16'h210e, 16'h4066, 16'h3fe3, 16'hfedf};
    bank_type lvl_nz;
    logic     acc;
    logic     rd;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            for (int i = 0; i < 16; i++) begin
                lvl_nz[b][i] = src_level[b][i] != 3'h0;
            end
        end
    end
    assign acc = apb_req.psel && apb_req.penable;
    assign rd  = acc && !apb_req.pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ******************************
    // Checks
    // ******************************
    level_gate_a: assert property ((src_req & ~$past(lvl_nz)) == '0)
        else $error("request with zero level");
    unimpl_req_a: assert property ((src_req & ~IMPL) == '0)
        else $error("request on unused bit");
    ready_now_a: assert property (acc |-> apb_rsp.pready)
        else $error("no ready in access");
    ready_idle_a: assert property (!apb_req.psel |-> !apb_rsp.pready)
        else $error("ready while idle");
    err_access_a: assert property (apb_rsp.pslverr |-> acc)
        else $error("error outside access");
    err_unmap_a: assert property (acc && apb_req.paddr >= 8'h28
        |-> apb_rsp.pslverr) else $error("no error on hole");
    err_mapped_a: assert property (acc && apb_req.paddr <= 8'h24
        && apb_req.paddr[1:0] == 2'b00 |-> !apb_rsp.pslverr)
        else $error("error on mapped word");
    hole_zero_a: assert property (rd && apb_req.paddr >= 8'h28
        |-> apb_rsp.prdata == '0) else $error("hole read not zero");
    unused_zero_a: assert property (rd && apb_req.paddr < 8'h20
        && apb_req.paddr[1:0] == 2'b00 |-> apb_rsp.prdata[31:16] == '0
        && (apb_rsp.prdata[15:0] & ~IMPL[apb_req.paddr[3:2]]) == '0)
        else $error("unused bits read nonzero");
    cover property (acc && apb_rsp.pslverr);
    cover property ($rose(irq));
    cover property ($rose(src_req[0][15]));
endmodule

// [tb/event_source_model.sv]
`timescale 1ns/1ps
module event_source_model (
    input wire logic                       pclk,
    output irq_enable_pkg::bank_type        src_event,
    output irq_enable_pkg::level_table_type src_level
);
    import irq_enable_pkg::*;
    // Pin routing is assumed done; events arrive here already mapped
    initial begin
        src_event = '0;
        src_level = '0;
    end
    // One cycle pulse, as a peripheral event strobe
    task automatic pulse(input bank_type bits);
        @(posedge pclk);
        src_event <= bits;
        @(posedge pclk);
        src_event <= '0;
    endtask
    task automatic set_level(input int b, input int i, input level_type lv);
        @(posedge pclk);
        src_level[b][i] <= lv;
    endtask
    task automatic set_all(input level_type lv);
        @(posedge pclk);
        src_level <= {64{lv}};
    endtask
endmodule

// [tb/tb_interrupt_enable_bank.sv]
`timescale 1ns/1ps
module tb_interrupt_enable_bank;
    import irq_enable_pkg::*;
    localparam bank_type IMPL = {16'h210e, 16'h4066, 16'h3fe3, 16'hfedf};
    logic            pclk;
    logic            presetn;
    apb_req_type     req;
    apb_rsp_type     rsp;
    bank_type        ev;
    bank_type        sreq;
    bank_type        exp_req;
    level_table_type lvl;
    logic            irq;
    int              mismatches;
    int              checks;
    interrupt_enable_bank dut_u (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .src_event(ev), .src_level(lvl),
        .src_req(sreq), .irq(irq));
    event_source_model src_u (.pclk(pclk), .src_event(ev), .src_level(lvl));
    // ******************************
    // Access and compare tasks
    // ******************************
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge pclk);
    endtask
    task automatic cmp_rd(input logic [32:0] exp, input logic [32:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected read exp %h got %h", exp, got);
        end
    endtask
    task automatic cmp_out(input string nm, input logic [15:0] exp,
        input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
        input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        cmp_rd({exp_err, exp}, {e, r});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ******************************
    // Stimulus
    // ******************************
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        mismatches++;
        stop_test();
    end
    initial begin
        mismatches = 0;
        checks = 0;
        presetn = 1'b0;
        req = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int b = 0; b < 4; b++) rd_chk(8'(4 * b), 32'h0, 1'b0);
        for (int b = 0; b < 4; b++) begin
            wr(8'(4 * b), 32'hffff_ffff);
            rd_chk(8'(4 * b), {16'h0, IMPL[b]}, 1'b0);
            wr(8'(4 * b), 32'h0);
            rd_chk(8'(4 * b), 32'h0, 1'b0);
        end
        wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0, 1'b1);
        for (int b = 0; b < 4; b++) if (b != 1) wr(8'(4 * b), 32'hffff_ffff);
        src_u.set_all(3'h4);
        src_u.set_level(0, 14, 3'h0);
        // Every bit fires, unused ones too, to prove they stay dead
        src_u.pulse({4{16'hffff}});
        @(posedge pclk);
        #1;
        exp_req = {IMPL[3], IMPL[2], 16'h0, IMPL[0] & 16'hbfff};
        for (int b = 0; b < 4; b++) cmp_out("src_req", exp_req[b], sreq[b]);
        rd_chk(8'h14, {16'h0, IMPL[1]}, 1'b0);
        rd_chk(8'h20, 32'hd, 1'b0);
        cmp_out("irq", 16'h0, {15'h0, irq});
        wr(8'h24, 32'h1);
        cmp_out("irq", 16'h1, {15'h0, irq});
        wr(8'h20, 32'hf);
        cmp_out("irq", 16'h0, {15'h0, irq});
        rd_chk(8'h20, 32'h0, 1'b0);
        wr(8'h00, 32'h0);
        wr(8'h1c, 32'h0);
        @(posedge pclk);
        #1;
        cmp_out("src_req", 16'h0, sreq[0]);
        cmp_out("src_req", 16'h0, sreq[3]);
        cmp_out("src_req", IMPL[2], sreq[2]);
        stop_test();
    end
endmodule
bind interrupt_enable_bank irq_enable_assertions chk_u (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .src_event(src_event), .src_level(src_level), .src_req(src_req),
    .irq(irq));
